// ---- common/supply_fault_pkg.sv ----
// Shared constants, field layouts and types of the supply fault supervisor
package supply_fault_pkg;
   // Clock and timing figures
   localparam int CLK_PERIOD_NS = 8;
   localparam int DEBOUNCE_NS   = 60000;
   localparam int HOLDOFF_NS    = 500000;
   localparam int DEBOUNCE_CYC  =
      (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLDOFF_CYC   =
      (HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TEST_CYC      = 16;
   localparam int SYNC_STAGES   = 2;

   // Register bus geometry and offsets
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] ADDR_FLAG   = 8'h00;
   localparam logic [7:0] ADDR_CLEAR  = 8'h04;
   localparam logic [7:0] ADDR_MASK   = 8'h08;
   localparam logic [7:0] ADDR_CONFIG = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;

   // Field positions and reset values
   localparam int CFG_BUCKB_RST_BIT = 0;
   localparam int STAT_STATE_LSB    = 0;
   localparam int STAT_OSC_SEL      = 4;
   localparam int STAT_IRQ          = 5;
   localparam int STAT_BIST_ERR     = 6;
   localparam int STAT_HOST_RST     = 7;
   localparam int STAT_POWER_UP     = 8;
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;
   localparam logic [31:0] CFG_RESET  = 32'h0000_0000;

   localparam int NUM_DET   = 21;
   localparam int NUM_FAULT = 23;

   // Detector flags, bit 0 is temp_shutdown
   typedef struct packed {
      logic battery_low;
      logic buck_a_over;
      logic buck_a_under;
      logic buck_a_overcurrent;
      logic buck_b_over;
      logic buck_b_under;
      logic buck_b_overcurrent;
      logic switched_rail_under;
      logic linreg_a_over;
      logic linreg_a_under_warn;
      logic linreg_a_under_reset;
      logic linreg_b_over;
      logic linreg_b_under;
      logic converter_rail_over;
      logic converter_rail_under;
      logic tracker_a_over;
      logic tracker_a_under;
      logic tracker_b_over;
      logic tracker_b_under;
      logic temp_warning;
      logic temp_shutdown;
   } det_t;

   // Latched fault word, as read from the flag register
   typedef struct packed {
      logic osc_fail;
      logic bist_fail;
      det_t det;
   } fault_t;

   // Commands to the regulators
   typedef struct packed {
      logic stop_all;
      logic buck_a_halt;
      logic buck_b_halt;
      logic buck_a_hiccup;
      logic buck_b_hiccup;
      logic protect_mode;
   } reg_cmd_t;

   typedef enum logic [2:0] {
      ST_DET_TEST,
      ST_LOGIC_TEST,
      ST_TEMP_TEST,
      ST_RUN,
      ST_HALT
   } bist_state_t;
endpackage

// ---- logic/supply_fault_supervisor.sv ----
// Fault response and power-up self-test supervisor for the supply rails
//
// Overview of operation
// R1: Ignore detectors until self-test finishes
// R2: Any over/under voltage drives interrupt low
// R3: Buck B detector results stay latched; over/under actions use latched flags, overcurrent acts off the live view
// R4: Buck B under-voltage needs 60us persistence
// R5: Option: buck B under-voltage resets host
// R6: Battery low stops every regulator, interrupts
// R7: Buck A over-voltage halts both bucks
// R8: Buck A under/overcurrent gives hiccup
// R9: Linreg A first low asserts suspend
// R10: Linreg A deep low resets host
// R11: Linreg B low puts buck A hiccup
// R12: Buck B over halts B, hiccups A
// R13: Buck B under/overcurrent enters protect mode
// R14: Other detectors only raise interrupt
// R15: Shutdown temperature stops all operation
// R16: Self-test runs while host reset held
// R17: Detector test fail raises interrupt
// R18: Timer logic fail blocks power-up
// R19: Bad oscillator swapped out, interrupt raised
// R20: Thermal path test fail raises interrupt
// R21: Self-test error holds interrupt low
// R22: Host clears flags by writing ones
// R23: No interrupt re-assert for 500us
// R24: Two-stage sync on comparator flags
// R25: Interrupt is OR of unmasked flags
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module supply_fault_supervisor
#(
   parameter int DEBOUNCE_CYC = supply_fault_pkg::DEBOUNCE_CYC,
   parameter int HOLDOFF_CYC  = supply_fault_pkg::HOLDOFF_CYC,
   parameter int TEST_CYC     = supply_fault_pkg::TEST_CYC
)
(
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   input  wire supply_fault_pkg::det_t   det_in,
   input  wire logic                     bist_det_fail,
   input  wire logic                     bist_logic_fail,
   input  wire logic                     bist_temp_fail,
   input  wire logic                     osc_a_bad,
   input  wire logic                     osc_b_bad,
   input  wire logic [7:0]               addr,
   input  wire logic [31:0]              wdata,
   input  wire logic                     wr,
   input  wire logic                     rd,
   output logic [31:0]                   rdata,
   output logic                          fault_irq_n,
   output logic                          suspend_request_out,
   output logic                          host_reset_n,
   output logic                          power_up_enable,
   output supply_fault_pkg::reg_cmd_t    reg_cmd,
   output logic                          osc_select,
   output logic                          det_test_en,
   output logic                          logic_test_en,
   output logic                          temp_test_en
);

   localparam int DEB_W = $clog2(DEBOUNCE_CYC + 1);
   localparam int HO_W  = $clog2(HOLDOFF_CYC + 1);
   localparam int TC_W  = $clog2(TEST_CYC + 1);
   localparam int NF    = supply_fault_pkg::NUM_FAULT;
   localparam int ND    = supply_fault_pkg::NUM_DET;

   supply_fault_pkg::bist_state_t state;
   supply_fault_pkg::bist_state_t next_state;
   logic [TC_W-1:0]  phase_cnt;
   logic             phase_end;
   logic             bist_err;
   logic             next_bist_err;
   logic             active;

   logic [ND-1:0]    sync_a;
   logic [ND-1:0]    sync_b;
   supply_fault_pkg::det_t live;
   supply_fault_pkg::det_t qual;

   logic [DEB_W-1:0] deb_cnt;
   logic             deb_ok;

   supply_fault_pkg::fault_t flag;
   supply_fault_pkg::fault_t set_vec;
   logic [NF-1:0]    clr_vec;
   logic [NF-1:0]    next_flag;
   logic [NF-1:0]    mask;
   logic [31:0]      cfg;
   logic             buckb_rst_en;

   logic             pending;
   logic             irq_on;
   logic             next_irq;
   logic [HO_W-1:0]  holdoff;
   logic             osc_swap;

   supply_fault_pkg::reg_cmd_t next_cmd;
   logic             next_suspend_request_out;
   logic             next_host_rst_n;

   logic             wr_clear;
   logic             wr_mask;
   logic             wr_cfg;
   logic [31:0]      status_word;
   logic [31:0]      next_rdata;

   // Two-flop synchroniser per comparator flag
   genvar gi;
   generate
      for (gi = 0; gi < ND; gi++)
      begin : g_sync
         // R24: two sync stages
         always_ff @(posedge clk)
         begin
            if (!rst_b)
            begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
            end
            else
            begin
               sync_a[gi] <= det_in[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate

   assign live = supply_fault_pkg::det_t'(sync_b);

   // Buck B under-voltage glitch filter
   // R4: 60us persistence counter
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         deb_cnt <= '0;
      else if (!live.buck_b_under)
         deb_cnt <= '0;
      else if (!deb_ok)
         deb_cnt <= deb_cnt + DEB_W'(1);
   end

   assign deb_ok = (deb_cnt == DEB_W'(DEBOUNCE_CYC));

   // Qualified detector view; nothing counts before self-test ends
   always_comb
   begin
      qual = live;
      qual.buck_b_under = deb_ok;
      // R1: gate until run
      if (!active)
         qual = '0;
   end

   // Self-test sequencer, one fixed slot per checked block
   assign phase_end = (phase_cnt == TC_W'(TEST_CYC - 1));
   assign active    = (state == supply_fault_pkg::ST_RUN);

   always_comb
   begin
      next_state    = state;
      next_bist_err = bist_err;
      unique case (state)
         supply_fault_pkg::ST_DET_TEST:
         begin
            // R17: detector check
            if (phase_end)
            begin
               next_bist_err = bist_err | bist_det_fail;
               next_state    = supply_fault_pkg::ST_LOGIC_TEST;
            end
         end
         supply_fault_pkg::ST_LOGIC_TEST:
         begin
            // R18: timer check blocks start
            if (phase_end)
            begin
               next_bist_err = bist_err | bist_logic_fail;
               next_state    = bist_logic_fail ?
                               supply_fault_pkg::ST_HALT :
                               supply_fault_pkg::ST_TEMP_TEST;
            end
         end
         supply_fault_pkg::ST_TEMP_TEST:
         begin
            // R20: thermal path check
            if (phase_end)
            begin
               next_bist_err = bist_err | bist_temp_fail;
               next_state    = supply_fault_pkg::ST_RUN;
            end
         end
         supply_fault_pkg::ST_RUN:
            next_state = state;
         supply_fault_pkg::ST_HALT:
            next_state = state;
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state     <= supply_fault_pkg::ST_DET_TEST;
         phase_cnt <= '0;
         bist_err  <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         bist_err  <= next_bist_err;
         phase_cnt <= (phase_end || next_state != state) ?
                      '0 : phase_cnt + TC_W'(1);
      end
   end

   // Test enables steer the analog test muxes
   assign det_test_en   = (state == supply_fault_pkg::ST_DET_TEST);
   assign logic_test_en = (state == supply_fault_pkg::ST_LOGIC_TEST);
   assign temp_test_en  = (state == supply_fault_pkg::ST_TEMP_TEST);

   // Oscillator cross-check; swap only to a healthy partner
   // R19: switch to good oscillator
   assign osc_swap = osc_select ? (osc_b_bad & ~osc_a_bad)
                                : (osc_a_bad & ~osc_b_bad);

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         osc_select <= 1'b0;
      else if (osc_swap)
         osc_select <= ~osc_select;
   end

   // Events that set latched flags
   // R2: voltage detectors latch
   // R14: interrupt-only detectors
   always_comb
   begin
      set_vec           = '0;
      set_vec.det       = qual;
      set_vec.bist_fail = next_bist_err & ~bist_err;
      // R19: flag bad oscillator
      set_vec.osc_fail  = osc_a_bad | osc_b_bad;
   end

   // Bus decode
   assign wr_clear = wr && (addr == supply_fault_pkg::ADDR_CLEAR);
   assign wr_mask  = wr && (addr == supply_fault_pkg::ADDR_MASK);
   assign wr_cfg   = wr && (addr == supply_fault_pkg::ADDR_CONFIG);

   // R22: write one clears
   assign clr_vec   = wr_clear ? wdata[NF-1:0] : '0;
   // Set beats a same-cycle clear so no event is lost
   assign next_flag = (flag & ~clr_vec) | set_vec;

   // Flags, mask and configuration
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         flag <= '0;
         mask <= supply_fault_pkg::MASK_RESET[NF-1:0];
         cfg  <= supply_fault_pkg::CFG_RESET;
      end
      else
      begin
         // R3: buck B stays latched
         flag <= next_flag;
         if (wr_mask)
            mask <= wdata[NF-1:0];
         if (wr_cfg)
            cfg <= wdata;
      end
   end

   assign buckb_rst_en = cfg[supply_fault_pkg::CFG_BUCKB_RST_BIT];

   // Interrupt: level from unmasked flags, with re-arm holdoff
   // R25: OR of unmasked flags
   assign pending = |(flag & ~mask);

   always_comb
   begin
      // R21: self-test error forces low
      if (bist_err)
         next_irq = 1'b1;
      else if (irq_on)
         next_irq = pending;
      // R23: wait out holdoff
      else
         next_irq = pending && (holdoff == '0);
   end

   // Holdoff starts when software has cleared the interrupt
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         irq_on  <= 1'b0;
         holdoff <= '0;
      end
      else
      begin
         irq_on <= next_irq;
         // R23: load 500us holdoff
         if (irq_on && !next_irq)
            holdoff <= HO_W'(HOLDOFF_CYC);
         else if (holdoff != '0)
            holdoff <= holdoff - HO_W'(1);
      end
   end

   // Regulator commands; buck B over and under actions run off latched flags, buck B overcurrent off the live view
   always_comb
   begin
      // R6: battery low stops all
      // R15: shutdown temperature stops all
      next_cmd.stop_all      = qual.battery_low | qual.temp_shutdown;
      // R7: buck A over halts bucks
      next_cmd.buck_a_halt   = qual.buck_a_over;
      // R12: buck B over halts B
      next_cmd.buck_b_halt   = qual.buck_a_over | flag.det.buck_b_over;
      // R8: buck A hiccup
      // R11: linreg B low hiccup
      next_cmd.buck_a_hiccup = qual.buck_a_under
                             | qual.buck_a_overcurrent
                             | qual.linreg_b_under
                             | flag.det.buck_b_over;
      // R13: buck B protect mode
      next_cmd.buck_b_hiccup = qual.buck_b_overcurrent
                             | flag.det.buck_b_under;
      next_cmd.protect_mode  = next_cmd.buck_b_hiccup;
   end

   // R9: suspend on first low
   assign next_suspend_request_out = qual.linreg_a_under_warn;

   // Host reset: held through self-test, then fault driven
   // R16: reset held during test
   // R10: deep low resets host
   // R5: optional buck B reset
   // Released on the same edge as power_up_enable, not a cycle later
   assign next_host_rst_n = ~((next_state != supply_fault_pkg::ST_RUN)
                              | qual.linreg_a_under_reset
                              | (buckb_rst_en & flag.det.buck_b_under));

   // Output flops
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         reg_cmd             <= '0;
         suspend_request_out <= 1'b0;
         host_reset_n        <= 1'b0;
         power_up_enable     <= 1'b0;
         fault_irq_n         <= 1'b1;
      end
      else
      begin
         reg_cmd             <= next_cmd;
         suspend_request_out <= next_suspend_request_out;
         host_reset_n        <= next_host_rst_n;
         // R18: no power-up after halt
         power_up_enable     <= (next_state == supply_fault_pkg::ST_RUN);
         // R2: interrupt active low
         fault_irq_n         <= ~next_irq;
      end
   end

   // Status word shows the block's own state
   always_comb
   begin
      status_word = '0;
      status_word[supply_fault_pkg::STAT_STATE_LSB +: 3] = state;
      status_word[supply_fault_pkg::STAT_OSC_SEL]  = osc_select;
      status_word[supply_fault_pkg::STAT_IRQ]      = irq_on;
      status_word[supply_fault_pkg::STAT_BIST_ERR] = bist_err;
      status_word[supply_fault_pkg::STAT_HOST_RST] = ~host_reset_n;
      status_word[supply_fault_pkg::STAT_POWER_UP] = power_up_enable;
   end

   // Read mux; clear register and unmapped space read zero
   always_comb
   begin
      next_rdata = '0;
      unique case (addr)
         supply_fault_pkg::ADDR_FLAG:
            next_rdata[NF-1:0] = flag;
         supply_fault_pkg::ADDR_MASK:
            next_rdata[NF-1:0] = mask;
         supply_fault_pkg::ADDR_CONFIG:
            next_rdata = cfg;
         supply_fault_pkg::ADDR_STATUS:
            next_rdata = status_word;
         default:
            next_rdata = '0;
      endcase
   end

   // Read data stands one cycle after the strobe only
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         rdata <= '0;
      else if (rd)
         rdata <= next_rdata;
      else
         rdata <= '0;
   end

endmodule

`default_nettype wire

// ---- tb/host_model.sv ----
// Host controller model that watches the interrupt and reset lines
`timescale 1ns/1ps
`default_nettype none
module host_model
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       fault_irq_n,
   input  wire logic       host_reset_n,
   output logic [7:0]      irq_count
);
   logic irq_d;

   // Count interrupt falls; a host held in reset forgets them
   always_ff @(posedge clk)
   begin
      irq_d <= fault_irq_n;
      if (!rst_b || !host_reset_n)
      begin
         irq_count <= 8'h00;
      end
      else if (irq_d && !fault_irq_n)
      begin
         irq_count <= irq_count + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ---- tb/supply_fault_chk.sv ----
// Assertion checker for the supply fault supervisor ports
`timescale 1ns/1ps
`default_nettype none
module supply_fault_chk
(
   input wire logic                       clk,
   input wire logic                       rst_b,
   input wire supply_fault_pkg::det_t     det_in,
   input wire logic                       osc_a_bad,
   input wire logic                       osc_b_bad,
   input wire logic                       wr,
   input wire logic [31:0]                rdata,
   input wire logic                       fault_irq_n,
   input wire logic                       suspend_request_out,
   input wire logic                       host_reset_n,
   input wire logic                       power_up_enable,
   input wire supply_fault_pkg::reg_cmd_t reg_cmd,
   input wire logic                       osc_select,
   input wire logic                       det_test_en,
   input wire logic                       logic_test_en,
   input wire logic                       temp_test_en
);
   // Any self-test phase running
   wire in_test = det_test_en | logic_test_en | temp_test_en;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_RST_QUIET:
   assert property (disable iff (1'h0) !rst_b |=> fault_irq_n
      && !host_reset_n && !power_up_enable && reg_cmd == '0 && rdata == '0)
      else $error("outputs not quiet after reset");
   AST_TEST_QUIET:
   assert property (in_test |-> !host_reset_n && !power_up_enable
      && reg_cmd == '0 && !suspend_request_out)
      else $error("regulator action during self-test");
   AST_PUP_REL:
   assert property ($rose(power_up_enable) |-> $rose(host_reset_n)
      && $past(temp_test_en)) else $error("power up out of order");
   AST_OSC_SWAP:
   assert property (osc_a_bad && !osc_b_bad && !osc_select |=> osc_select)
      else $error("oscillator not swapped");
   AST_HOLDOFF:
   assert property ($rose(fault_irq_n) |=> fault_irq_n[*8])
      else $error("interrupt back inside holdoff");
   AST_BOTH_HALT:
   assert property (reg_cmd.buck_a_halt |-> reg_cmd.buck_b_halt)
      else $error("buck a halted alone");
   AST_BUCKB_OVER:
   assert property (reg_cmd.buck_b_halt && !reg_cmd.buck_a_halt
      |-> reg_cmd.buck_a_hiccup) else $error("buck a not in hiccup");
   AST_PROTECT:
   assert property (reg_cmd.protect_mode |-> reg_cmd.buck_b_hiccup)
      else $error("protect without buck b hiccup");
   AST_LATCH:
   assert property (reg_cmd.buck_b_halt && !reg_cmd.buck_a_halt && !wr
      && !$past(wr)
      && !$past(wr, 2) |=> reg_cmd.buck_b_halt)
      else $error("buck b halt released without clear");
   AST_STOP_SYNC:
   assert property ($rose(reg_cmd.stop_all) |-> $past(det_in.battery_low, 2)
      || $past(det_in.temp_shutdown, 2)) else $error("stop too early");
   AST_HOST_RST:
   assert property ($fell(host_reset_n) |->
      $past(det_in.linreg_a_under_reset, 2) || $past(det_in.buck_b_under, 2))
      else $error("host reset without cause");
   AST_SUSPEND_REQUEST_OUT:
   assert property ($rose(suspend_request_out) |->
      $past(det_in.linreg_a_under_warn, 2)) else $error("suspend no cause");
endmodule
`default_nettype wire

bind supply_fault_supervisor supply_fault_chk supply_fault_chk_inst (
   .clk, .rst_b, .det_in, .osc_a_bad, .osc_b_bad, .wr, .rdata, .fault_irq_n,
   .suspend_request_out, .host_reset_n, .power_up_enable, .reg_cmd,
   .osc_select, .det_test_en, .logic_test_en, .temp_test_en
);

// ---- tb/supply_fault_supervisor_test.sv ----
// Self-checking bench for the supply fault supervisor
`timescale 1ns/1ps
`default_nettype none
module supply_fault_supervisor_test;
   localparam int DB = 8;
   localparam int HO = 20;
   localparam int TC = 4;
   logic                       clk = 1'h0;
   logic                       rst_b = 1'h0;
   supply_fault_pkg::det_t     det = '0;
   logic                       bdf = 1'h0;
   logic                       blf = 1'h0;
   logic                       btf = 1'h0;
   logic                       oab = 1'h0;
   logic                       obb = 1'h0;
   logic [7:0]                 addr = 8'h00;
   logic [31:0]                wdata = 32'h0;
   logic                       wr = 1'h0;
   logic                       rd = 1'h0;
   logic [31:0]                rdata;
   logic                       irq_n;
   logic                       sreq;
   logic                       hrst_n;
   logic                       pup;
   supply_fault_pkg::reg_cmd_t cmd;
   logic                       osc_sel;
   logic                       dten;
   logic [7:0]                 n_irq;
   logic [7:0]                 irq0;
   int                         b;
   int                         n_fail = 0;
   int                         checks_done = 0;
   int                         cyc = 0;

   supply_fault_supervisor #(.DEBOUNCE_CYC(DB), .HOLDOFF_CYC(HO),
      .TEST_CYC(TC)) supply_fault_supervisor_inst (
      .clk(clk), .rst_b(rst_b), .det_in(det), .bist_det_fail(bdf),
      .bist_logic_fail(blf), .bist_temp_fail(btf), .osc_a_bad(oab),
      .osc_b_bad(obb), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .fault_irq_n(irq_n), .suspend_request_out(sreq),
      .host_reset_n(hrst_n), .power_up_enable(pup), .reg_cmd(cmd),
      .osc_select(osc_sel), .det_test_en(dten), .logic_test_en(),
      .temp_test_en());

   host_model host_model_inst (.clk(clk), .rst_b(rst_b),
      .fault_irq_n(irq_n), .host_reset_n(hrst_n), .irq_count(n_irq));

   always #4 clk = ~clk;

   // Cycle ceiling so a hang still ends in the report
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_fail++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      checks_done++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One-cycle strobes, a quiet cycle after so no double drive
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      wr <= 1'h1;
      addr <= a;
      wdata <= d;
      tick(1);
      wr <= 1'h0;
      tick(1);
   endtask

   task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp,
                         input string what);
      rd <= 1'h1;
      addr <= a;
      tick(1);
      rd <= 1'h0;
      #1;
      chk(rdata, exp, what);
      tick(1);
   endtask

   // Reset with chosen self-test failures, then wait for power up
   task automatic boot(input logic [2:0] fails);
      rst_b <= 1'h0;
      det <= '0;
      {bdf, blf, btf} <= fails;
      tick(3);
      rst_b <= 1'h1;
      for (int i = 0; i < 40 && pup !== 1'h1; i++)
         tick(1);
   endtask

   // Expected {suspend, host reset, commands} for one detector
   function automatic logic [7:0] exp_out(input int d);
      logic [5:0] c;
      case (d)
         20, 0:     c = 6'h20;
         19:        c = 6'h18;
         18, 17, 8: c = 6'h04;
         16:        c = 6'h0C;
         14:        c = 6'h03;
         default:   c = 6'h00;
      endcase
      return {d == 11, d != 10, c};
   endfunction

   initial
   begin
      // Reset, then detector noise inside the self-test window
      tick(3);
      chk(irq_n, 1, "irq in reset");
      chk(hrst_n, 0, "host reset held");
      chk(dten, 1, "detector test");
      rst_b <= 1'h1;
      det.tracker_a_over <= 1'h1;
      tick(2 * TC);
      det <= '0;
      tick(3 * TC);
      chk(hrst_n, 1, "host reset released");
      bus_rd(supply_fault_pkg::ADDR_FLAG, 0, "flags after test");
      bus_rd(supply_fault_pkg::ADDR_MASK, 0, "mask reset");
      bus_rd(supply_fault_pkg::ADDR_CONFIG, 0, "config reset");
      bus_wr(supply_fault_pkg::ADDR_FLAG, 32'hFFFF_FFFF);
      bus_rd(8'h20, 0, "unmapped");
      bus_rd(supply_fault_pkg::ADDR_FLAG, 0, "flag read only");
      $display("test self_test done");
      // Every detector alone except buck B under-voltage; battery and shutdown come last
      for (int i = 1; i <= 21; i++)
      begin
         b = i % 21;
         if (b != 15)
         begin
            det <= supply_fault_pkg::det_t'(21'h1 << b);
            tick(6);
            chk({sreq, hrst_n, cmd}, exp_out(b), "response");
            bus_rd(supply_fault_pkg::ADDR_FLAG, 32'h1 << b, "flag");
            det <= '0;
            tick(6);
            chk(cmd, (b == 16) ? 6'h0C : 6'h00, "latched");
            bus_wr(supply_fault_pkg::ADDR_CLEAR, 32'hFFFF_FFFF);
            tick(4);
            chk(cmd, 0, "commands cleared");
         end
      end
      $display("test detector_table done");
      // Buck B glitch, then a real fault with host reset enabled
      boot(3'h0);
      bus_wr(supply_fault_pkg::ADDR_CONFIG, 32'h1);
      det.buck_b_under <= 1'h1;
      tick(DB - 2);
      det <= '0;
      tick(6);
      bus_rd(supply_fault_pkg::ADDR_FLAG, 0, "glitch");
      det.buck_b_under <= 1'h1;
      tick(DB + 10);
      chk({hrst_n, cmd}, 7'h03, "buck b under");
      det <= '0;
      tick(6);
      chk({hrst_n, cmd}, 7'h03, "buck b held");
      bus_rd(supply_fault_pkg::ADDR_FLAG, 32'h8000, "buck b flag");
      bus_wr(supply_fault_pkg::ADDR_CLEAR, 32'h8000);
      tick(4);
      chk({hrst_n, cmd}, 7'h40, "buck b released");
      $display("test debounce done");
      // Interrupt, clear, holdoff, mask
      tick(HO + 5);
      irq0 = n_irq;
      det.tracker_a_over <= 1'h1;
      tick(5);
      chk(irq_n, 0, "irq raised");
      det <= '0;
      tick(4);
      bus_wr(supply_fault_pkg::ADDR_CLEAR, 32'h20);
      tick(2);
      chk(irq_n, 1, "irq cleared");
      det.tracker_b_over <= 1'h1;
      tick(8);
      chk(irq_n, 1, "irq held off");
      tick(HO);
      chk(irq_n, 0, "irq after holdoff");
      chk(n_irq - irq0, 2, "host irq count");
      det <= '0;
      tick(4);
      bus_wr(supply_fault_pkg::ADDR_CLEAR, 32'h8);
      bus_wr(supply_fault_pkg::ADDR_MASK, 32'h7F_FFFF);
      det.temp_warning <= 1'h1;
      tick(HO + 8);
      chk(irq_n, 1, "masked");
      bus_wr(supply_fault_pkg::ADDR_MASK, 32'h0);
      tick(3);
      chk(irq_n, 0, "unmasked");
      det <= '0;
      tick(4);
      bus_wr(supply_fault_pkg::ADDR_CLEAR, 32'h2);
      $display("test interrupt done");
      // Oscillator failure swaps clocks and reports
      oab <= 1'h1;
      tick(2);
      chk(osc_sel, 1, "osc swap");
      oab <= 1'h0;
      tick(HO + 5);
      chk(irq_n, 0, "osc irq");
      bus_rd(supply_fault_pkg::ADDR_FLAG, 32'h40_0000, "osc flag");
      $display("test oscillator done");
      // Self-test failures
      boot(3'h4);
      bus_wr(supply_fault_pkg::ADDR_CLEAR, 32'hFFFF_FFFF);
      bus_wr(supply_fault_pkg::ADDR_MASK, 32'h7F_FFFF);
      tick(HO + 5);
      chk(irq_n, 0, "detector test fail");
      boot(3'h1);
      tick(HO + 5);
      chk(irq_n, 0, "thermal test fail");
      boot(3'h2);
      chk(pup, 0, "halted");
      chk(hrst_n, 0, "host kept in reset");
      bus_rd(supply_fault_pkg::ADDR_STATUS, 32'hE4, "status halted");
      $display("test self_test_fail done");
      stop_test();
   end
endmodule
`default_nettype wire
